// file: rtl/gtc_pkg.sv
// Constants, register map and field layout of the general timer control logic
//
// Function
// - Manual output set or clear beats any channel action in that cycle.
// - Manual set and clear of one output together are both ignored.
// - Channel actions on one output: clear beats set, set toggle, toggle pulse.
// - Each IO output has a complement that is always its inverse.
// - Outside mode off the counter advances only on prescaler ticks.
// - Prescaler counts down from tick divisor; zero gives one tick, reloads.
// - Timer tick rate is tick source rate over tick divisor plus one.
// - Prescaler event output goes high before prescaler zero, as configured.
// - One shared filter setting, active only for channels in capture mode.
// - Filter passes input after match length plus one equal samples.
// - Two differing consecutive samples reload the filter counter.
// - Debug halt or fault stops counter; with mode not off, IO outputs take park levels meanwhile.
// - Deadband enabled IO outputs wait the deadband delay before park level.
// - Setting of the selected raw flag raises a DMA request.
// - Each DMA request loads the window pointer with start index times four.
// - Each window port access hits the pointed register, pointer plus four.
// - After the word count of accesses, window accesses have no effect.
// - Setting of the selected raw flag raises the converter trigger.
// - A raw flag reaches masked status only while its mask bit is one.
// - Raw status shows all events; writing one to clear register clears.
// - Masked status is mask AND raw status, bit by bit.
// - Writing one to the set register sets the raw flag.
package gtc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_MODULE_DESCRIPTION = 12'h000;
  localparam logic [11:0] OFS_MODULE_PARAMETERS = 12'h004;
  localparam logic [11:0] OFS_START = 12'h008;
  localparam logic [11:0] OFS_CTL = 12'h00C;
  localparam logic [11:0] OFS_MANUAL_OUTPUT_CONTROL = 12'h010;
  localparam logic [11:0] OFS_COUNTER_VALUE = 12'h014;
  localparam logic [11:0] OFS_PRESCALER_CONFIG = 12'h018;
  localparam logic [11:0] OFS_PREEVT = 12'h01C;
  localparam logic [11:0] OFS_FILT = 12'h020;
  localparam logic [11:0] OFS_FAULT = 12'h024;
  localparam logic [11:0] OFS_PARK = 12'h028;
  localparam logic [11:0] OFS_DEADBAND_DELAY_VALUES = 12'h02C;
  localparam logic [11:0] OFS_DBEN = 12'h030;
  localparam logic [11:0] OFS_DMA = 12'h03C;
  localparam logic [11:0] OFS_DMAWIN = 12'h040;
  localparam logic [11:0] OFS_CONVERTER_TRIGGER_CONFIG = 12'h044;
  localparam logic [11:0] OFS_IOOVR = 12'h048;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h068;
  localparam logic [11:0] OFS_RIS = 12'h06C;
  localparam logic [11:0] OFS_MIS = 12'h070;
  localparam logic [11:0] OFS_IRQ_SET = 12'h074;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h078;
  localparam logic [11:0] OFS_CHCFG0 = 12'h0C0;
  // Arbitrary identification value
  localparam logic [31:0] MODULE_DESCRIPTION_ID = 32'h0000_0001;
  localparam logic [31:0] MODULE_PARAMETERS_RST = 32'h0006_18C3;
  // Field positions
  localparam int TIMER_MODE_FIELD_LSB = 0;
  localparam int PRE_DIV_LSB = 0;
  localparam int PRE_SRC_BIT = 8;
  localparam int DMA_REQ_LSB = 0;
  localparam int DMA_ADDR_LSB = 8;
  localparam int DMA_CNT_LSB = 16;
  localparam int IOOVR_VAL_LSB = 8;
  localparam int CH_ACT_LSB = 16;
  localparam int CH_OEN_LSB = 20;
  localparam int CH_CAPT_BIT = 24;
  // Raw flag positions: zero crossing, then one flag per channel
  localparam int RIS_ZERO = 0;
  typedef enum logic [2:0] {
    GTC_ACT_NONE, GTC_ACT_CLR, GTC_ACT_SET, GTC_ACT_TGL, GTC_ACT_PLS
  } gtc_act_t;
endpackage

// file: rtl/gtc_top.sv
// General timer control logic with APB register slave
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module gtc_top
  import gtc_pkg::*;
#(
  parameter int NCH = 3,
  parameter int NOUT = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic tickIn,
  input wire logic [NCH-1:0] chIn,
  input wire logic faultIn,
  input wire logic debugHalt,
  output logic [NOUT-1:0] evOut,
  output logic [NOUT-1:0] ioOut,
  output logic [NOUT-1:0] ioOutN,
  output logic prescaler_event_config,
  output logic dmaReq,
  output logic adcTrig
);
  localparam int NRIS = NCH + 1;

  logic pready_r;
  logic [31:0] prdata_r;
  logic [31:0] synchronized_start_config_r, ctl_r, prescaler_config_r, preEvt_r, filtCfg_r, faultCfg_r;
  logic [31:0] park_r, deadband_delay_values_r, dbEn_r, dmaCfg_r, adcCfg_r, ioOvr_r, irq_mask_r;
  logic [31:0] chCfg_r [NCH];
  logic [15:0] cnt_r;
  logic [7:0] pre_r;
  logic tickInPrev_r;
  logic [NRIS-1:0] ris_r;
  logic [NOUT-1:0] out_r, pulseOn_r, ioOut_r, ioOutN_r;
  logic prescaler_event_config_r, dmaReq_r, adcTrig_r;
  logic [11:0] dmaPtr_r;
  logic [4:0] dmaLeft_r;
  logic parkReqPrev_r;
  logic [11:0] dbCnt_r;
  logic [NOUT-1:0] parkHold_r;
  logic [7:0] filtCnt_r [NCH];
  logic [NCH-1:0] sample_r, filt_r, filtPrev_r;

  // Bus decode; window port accesses are redirected to the pointed register
  wire busAcc = psel && penable && pready_r;
  wire isWin = (paddr == OFS_DMAWIN);
  wire winOk = (dmaLeft_r != 5'h0) && (dmaPtr_r != OFS_DMAWIN);
  wire [11:0] effAddr = isWin ? dmaPtr_r : paddr;
  wire accOk = !isWin || winOk;
  wire wrEn = busAcc && pwrite && accOk;
  wire winAcc = busAcc && isWin && winOk;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // Timer control
  wire modeOn = (ctl_r[TIMER_MODE_FIELD_LSB +: 2] != 2'h0);
  wire parkReq = debugHalt || (faultCfg_r[0] && faultIn);
  wire run = modeOn && !parkReq;
  wire [7:0] tick_divisor = prescaler_config_r[PRE_DIV_LSB +: 8];
  wire srcEv = prescaler_config_r[PRE_SRC_BIT] ? (tickIn && !tickInPrev_r) : 1'b1;
  wire tick = run && srcEv && (pre_r == 8'h0);
  wire [7:0] preNxt = !run ? tick_divisor : !srcEv ? pre_r : (pre_r == 8'h0) ? tick_divisor : pre_r - 8'h1;
  wire [15:0] cntNxt = cnt_r + 16'h1;
  wire zeroEv = tick && (cntNxt == 16'h0);

  // Channel events and actions
  logic [NCH-1:0] cmpHit, captHit;
  logic [NOUT-1:0] aClr, aSet, aTgl, aPls;
  always_comb begin
    aClr = '0;
    aSet = '0;
    aTgl = '0;
    aPls = '0;
    for (int c = 0; c < NCH; c++) begin
      cmpHit[c] = tick && !chCfg_r[c][CH_CAPT_BIT] && (cnt_r == chCfg_r[c][15:0]);
      captHit[c] = run && chCfg_r[c][CH_CAPT_BIT] && filt_r[c] && !filtPrev_r[c];
      if (cmpHit[c] || captHit[c]) begin
        case (gtc_act_t'(chCfg_r[c][CH_ACT_LSB +: 3]))
          GTC_ACT_CLR: aClr = aClr | chCfg_r[c][CH_OEN_LSB +: NOUT];
          GTC_ACT_SET: aSet = aSet | chCfg_r[c][CH_OEN_LSB +: NOUT];
          GTC_ACT_TGL: aTgl = aTgl | chCfg_r[c][CH_OEN_LSB +: NOUT];
          GTC_ACT_PLS: aPls = aPls | chCfg_r[c][CH_OEN_LSB +: NOUT];
          default: aClr = aClr;
        endcase
      end
    end
  end

  // Manual override from the output control register
  wire outCtlWr = wrEn && hit(effAddr, OFS_MANUAL_OUTPUT_CONTROL);
  logic [NOUT-1:0] manSet, manClr, outNxt, pulseNxt;
  always_comb begin
    for (int o = 0; o < NOUT; o++) begin
      manSet[o] = outCtlWr && pwdata[2*o];
      manClr[o] = outCtlWr && pwdata[2*o+1];
      pulseNxt[o] = pulseOn_r[o] && !tick;
      if (manSet[o] && manClr[o]) begin
        outNxt[o] = out_r[o];
      end else if (manSet[o] || manClr[o]) begin
        outNxt[o] = manSet[o];
      end else if (aClr[o]) begin
        outNxt[o] = 1'b0;
      end else if (aSet[o]) begin
        outNxt[o] = 1'b1;
      end else if (aTgl[o]) begin
        outNxt[o] = !out_r[o];
      end else if (aPls[o]) begin
        outNxt[o] = 1'b1;
        pulseNxt[o] = 1'b1;
      end else if (pulseOn_r[o] && tick) begin
        outNxt[o] = 1'b0;
      end else begin
        outNxt[o] = out_r[o];
      end
    end
  end

  // Park level with deadband delay ahead of it
  wire parkEntry = parkReq && !parkReqPrev_r;
  wire [NOUT-1:0] dbMask = dbEn_r[NOUT-1:0];
  wire [NOUT-1:0] holdNxt = parkEntry ? dbMask : (dbCnt_r <= 12'h1) ? '0 : parkHold_r;
  wire [NOUT-1:0] parkVal = (parkReq && modeOn) ? ((holdNxt & ioOut_r) | (~holdNxt & park_r[NOUT-1:0])) : outNxt;
  wire [NOUT-1:0] ovrEn = ioOvr_r[NOUT-1:0];
  wire [NOUT-1:0] ioNxt = (ovrEn & ioOvr_r[IOOVR_VAL_LSB +: NOUT]) | (~ovrEn & parkVal);

  // Raw flags: set wins over clear
  wire [NRIS-1:0] evSet = {(cmpHit | captHit), zeroEv};
  wire [NRIS-1:0] isetW = (wrEn && hit(effAddr, OFS_IRQ_SET)) ? pwdata[NRIS-1:0] : '0;
  wire [NRIS-1:0] iclrW = (wrEn && hit(effAddr, OFS_IRQ_CLEAR)) ? pwdata[NRIS-1:0] : '0;
  wire [NRIS-1:0] risNxt = (ris_r & ~iclrW) | evSet | isetW;
  wire [NRIS-1:0] risRise = risNxt & ~ris_r;
  wire [NRIS-1:0] masked_irq_status = irq_mask_r[NRIS-1:0] & ris_r;

  function automatic logic selRise(input logic [3:0] sel, input logic [NRIS-1:0] rise);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NRIS; i++) begin
      if (sel == 4'(i + 1)) begin
        r = rise[i];
      end
    end
    return r;
  endfunction

  wire dmaEv = selRise(dmaCfg_r[DMA_REQ_LSB +: 4], risRise);
  wire adcEv = selRise(adcCfg_r[3:0], risRise);

  // Read mux
  logic [31:0] rdVal;
  always_comb begin
    rdVal = 32'h0;
    case (effAddr)
      OFS_MODULE_DESCRIPTION: rdVal = MODULE_DESCRIPTION_ID;
      OFS_MODULE_PARAMETERS: rdVal = MODULE_PARAMETERS_RST;
      OFS_START: rdVal = synchronized_start_config_r;
      OFS_CTL: rdVal = ctl_r;
      OFS_COUNTER_VALUE: rdVal = {16'h0, cnt_r};
      OFS_PRESCALER_CONFIG: rdVal = prescaler_config_r;
      OFS_PREEVT: rdVal = preEvt_r;
      OFS_FILT: rdVal = filtCfg_r;
      OFS_FAULT: rdVal = faultCfg_r;
      OFS_PARK: rdVal = park_r;
      OFS_DEADBAND_DELAY_VALUES: rdVal = deadband_delay_values_r;
      OFS_DBEN: rdVal = dbEn_r;
      OFS_DMA: rdVal = dmaCfg_r;
      OFS_CONVERTER_TRIGGER_CONFIG: rdVal = adcCfg_r;
      OFS_IOOVR: rdVal = ioOvr_r;
      OFS_IRQ_MASK: rdVal = irq_mask_r;
      OFS_RIS: rdVal = 32'(ris_r);
      OFS_MIS: rdVal = 32'(masked_irq_status);
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (effAddr == OFS_CHCFG0 + 12'(4 * c)) begin
            rdVal = chCfg_r[c];
          end
        end
      end
    endcase
    if (!accOk) begin
      rdVal = 32'h0;
    end
  end

  // APB handshake: one wait state, then answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= rdVal;
      end
    end
  end

  // Register writes; description registers have no storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {synchronized_start_config_r, ctl_r, prescaler_config_r, preEvt_r, filtCfg_r, faultCfg_r} <= '0;
      {park_r, deadband_delay_values_r, dbEn_r, dmaCfg_r, adcCfg_r, ioOvr_r, irq_mask_r} <= '0;
      for (int c = 0; c < NCH; c++) begin
        chCfg_r[c] <= 32'h0;
      end
    end else if (wrEn) begin
      case (effAddr)
        OFS_START: synchronized_start_config_r <= pwdata;
        OFS_CTL: ctl_r <= pwdata;
        OFS_PRESCALER_CONFIG: prescaler_config_r <= pwdata;
        OFS_PREEVT: preEvt_r <= pwdata;
        OFS_FILT: filtCfg_r <= pwdata;
        OFS_FAULT: faultCfg_r <= pwdata;
        OFS_PARK: park_r <= pwdata;
        OFS_DEADBAND_DELAY_VALUES: deadband_delay_values_r <= pwdata;
        OFS_DBEN: dbEn_r <= pwdata;
        OFS_DMA: dmaCfg_r <= pwdata;
        OFS_CONVERTER_TRIGGER_CONFIG: adcCfg_r <= pwdata;
        OFS_IOOVR: ioOvr_r <= pwdata;
        OFS_IRQ_MASK: irq_mask_r <= pwdata;
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (effAddr == OFS_CHCFG0 + 12'(4 * c)) begin
              chCfg_r[c] <= pwdata;
            end
          end
        end
      endcase
    end
  end

  // Prescaler and counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= 8'h0;
      cnt_r <= 16'h0;
      tickInPrev_r <= 1'b0;
      prescaler_event_config_r <= 1'b0;
    end else begin
      pre_r <= preNxt;
      tickInPrev_r <= tickIn;
      prescaler_event_config_r <= run && (preNxt <= preEvt_r[7:0]);
      if (wrEn && hit(effAddr, OFS_COUNTER_VALUE)) begin
        cnt_r <= pwdata[15:0];
      end else if (tick) begin
        cnt_r <= cntNxt;
      end
    end
  end

  // Input filter per channel; one filter setting shared by all channels
  logic [7:0] filtCntNxt [NCH];
  logic [NCH-1:0] filtNxt;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      filtCntNxt[c] = filtCnt_r[c];
      filtNxt[c] = filt_r[c];
      if (!chCfg_r[c][CH_CAPT_BIT]) begin
        filtNxt[c] = chIn[c];
        filtCntNxt[c] = filtCfg_r[7:0];
      end else begin
        if (chIn[c] != sample_r[c]) begin
          filtCntNxt[c] = filtCfg_r[7:0];
        end else if (filtCnt_r[c] != 8'h0) begin
          filtCntNxt[c] = filtCnt_r[c] - 8'h1;
        end
        // Input is valid on the sample that brings the counter to zero
        if (filtCntNxt[c] == 8'h0) begin
          filtNxt[c] = chIn[c];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_r <= '0;
      filt_r <= '0;
      filtPrev_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        filtCnt_r[c] <= 8'h0;
      end
    end else begin
      sample_r <= chIn;
      filt_r <= filtNxt;
      filtPrev_r <= filt_r;
      for (int c = 0; c < NCH; c++) begin
        filtCnt_r[c] <= filtCntNxt[c];
      end
    end
  end

  // Outputs, park and deadband
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= '0;
      pulseOn_r <= '0;
      ioOut_r <= '0;
      ioOutN_r <= '1;
      parkReqPrev_r <= 1'b0;
      dbCnt_r <= 12'h0;
      parkHold_r <= '0;
    end else begin
      out_r <= outNxt;
      pulseOn_r <= pulseNxt;
      ioOut_r <= ioNxt;
      ioOutN_r <= ~ioNxt;
      parkReqPrev_r <= parkReq;
      parkHold_r <= holdNxt;
      dbCnt_r <= parkEntry ? deadband_delay_values_r[11:0] : (dbCnt_r != 12'h0) ? dbCnt_r - 12'h1 : 12'h0;
    end
  end

  // Raw flags, DMA pointer, requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ris_r <= '0;
      dmaReq_r <= 1'b0;
      adcTrig_r <= 1'b0;
      dmaPtr_r <= 12'h0;
      dmaLeft_r <= 5'h0;
    end else begin
      ris_r <= risNxt;
      dmaReq_r <= dmaEv;
      adcTrig_r <= adcEv;
      if (dmaEv) begin
        dmaPtr_r <= {dmaCfg_r[DMA_ADDR_LSB +: 10], 2'b00};
        dmaLeft_r <= dmaCfg_r[DMA_CNT_LSB +: 5];
      end else if (winAcc) begin
        dmaPtr_r <= dmaPtr_r + 12'h4;
        dmaLeft_r <= dmaLeft_r - 5'h1;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign evOut = out_r;
  assign ioOut = ioOut_r;
  assign ioOutN = ioOutN_r;
  assign prescaler_event_config = prescaler_event_config_r;
  assign dmaReq = dmaReq_r;
  assign adcTrig = adcTrig_r;

  // Checks
  sequence s_dmaLoad;
    dmaEv ##1 (dmaPtr_r == {dmaCfg_r[DMA_ADDR_LSB +: 10], 2'b00});
  endsequence
  sequence s_winStep;
    winAcc && !dmaEv ##1 (dmaPtr_r == $past(dmaPtr_r) + 12'h4);
  endsequence

  manual_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    (manSet[0] && !manClr[0]) |=> evOut[0]) else $error("manual set lost");
  both_ignored_a: assert property (@(posedge clk) disable iff (!arst_n)
    (manSet[0] && manClr[0]) |=> $stable(evOut[0])) else $error("set and clear not ignored");
  clear_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (aClr[0] && !manSet[0] && !manClr[0]) |=> !evOut[0]) else $error("channel clear lost priority");
  complement_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
    ioOutN == ~ioOut) else $error("complement output mismatch");
  tick_gated_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!run && !(wrEn && hit(effAddr, OFS_COUNTER_VALUE))) |=> $stable(cnt_r)) else $error("counter moved while stopped");
  prescale_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    tick |=> (pre_r == $past(tick_divisor))) else $error("prescaler reload wrong");
  dma_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dmaEv |-> s_dmaLoad) else $error("window pointer not loaded");
  dma_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (winAcc && !dmaEv) |-> s_winStep) else $error("window pointer not advanced");
  dma_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
    (dmaLeft_r == 5'h0 && !dmaEv) |=> $stable(dmaPtr_r)) else $error("pointer moved past count");
  mask_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (OFS_MIS == paddr && busAcc && !pwrite) |-> (prdata_r == 32'(irq_mask_r[NRIS-1:0] & ris_r)))
    else $error("masked status mismatch");
  set_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    (isetW[RIS_ZERO]) |=> ris_r[RIS_ZERO]) else $error("set register ignored");
  park_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (parkReq && modeOn && holdNxt == '0 && ovrEn == '0) |=> (ioOut == park_r[NOUT-1:0]))
    else $error("park level not applied");
endmodule // gtc_top
`default_nettype wire

// file: testbench/gtc_far_model.sv
// Far side model: tick source, request counters and IO pin watch
`timescale 1ns/10ps
`default_nettype none
module gtc_far_model
  import gtc_pkg::*;
#(
  parameter int NOUT = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tickIn,
  input wire logic dmaReq,
  input wire logic adcTrig,
  input wire logic [NOUT-1:0] ioOut,
  input wire logic [NOUT-1:0] ioOutN,
  output logic [15:0] dmaCnt,
  output logic [15:0] adcCnt,
  output logic [15:0] ioBad
);
  initial tickIn = 1'b0;
  // Tick source stands low between bursts
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tickIn <= 1'b1;
      repeat (2) @(posedge clk);
      tickIn <= 1'b0;
      @(posedge clk);
    end
  endtask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dmaCnt <= 16'h0000;
      adcCnt <= 16'h0000;
      ioBad <= 16'h0000;
    end else begin
      dmaCnt <= dmaCnt + 16'(dmaReq === 1'b1);
      adcCnt <= adcCnt + 16'(adcTrig === 1'b1);
      ioBad <= ioBad + 16'(ioOutN !== ~ioOut);
    end
  end
endmodule // gtc_far_model
`default_nettype wire

// file: testbench/general_timer_control_logic_bench.sv
// Self-checking bench for the general timer control logic
`timescale 1ns/10ps
`default_nettype none
module general_timer_control_logic_bench
  import gtc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic tickIn;
  logic [2:0] chIn = 3'h0;
  logic faultIn = 1'b0;
  logic debugHalt = 1'b0;
  logic [2:0] evOut;
  logic [2:0] ioOut;
  logic [2:0] ioOutN;
  logic prescaler_event_config;
  logic dmaReq;
  logic adcTrig;
  logic [15:0] dmaCnt;
  logic [15:0] adcCnt;
  logic [15:0] ioBad;
  logic [31:0] q;
  logic [31:0] v;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  gtc_top u_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .tickIn(tickIn),
    .chIn(chIn), .faultIn(faultIn), .debugHalt(debugHalt), .evOut(evOut), .ioOut(ioOut),
    .ioOutN(ioOutN), .prescaler_event_config(prescaler_event_config), .dmaReq(dmaReq), .adcTrig(adcTrig)
  );
  gtc_far_model u_far (
    .clk(clk), .arst_n(arst_n), .tickIn(tickIn), .dmaReq(dmaReq), .adcTrig(adcTrig),
    .ioOut(ioOut), .ioOutN(ioOutN), .dmaCnt(dmaCnt), .adcCnt(adcCnt), .ioBad(ioBad)
  );
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // APB transfer: held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_regs();
    logic [11:0] zr[17] = '{OFS_START, OFS_CTL, OFS_MANUAL_OUTPUT_CONTROL, OFS_COUNTER_VALUE, OFS_PRESCALER_CONFIG, OFS_PREEVT, OFS_FILT,
      OFS_FAULT, OFS_PARK, OFS_DEADBAND_DELAY_VALUES, OFS_DBEN, OFS_DMA, OFS_DMAWIN, OFS_CONVERTER_TRIGGER_CONFIG, OFS_IOOVR, OFS_IRQ_MASK, OFS_RIS};
    rc(OFS_MODULE_DESCRIPTION, MODULE_DESCRIPTION_ID);
    rc(OFS_MODULE_PARAMETERS, MODULE_PARAMETERS_RST);
    foreach (zr[i]) rc(zr[i], 32'h0000_0000);
    wr(OFS_MODULE_DESCRIPTION, 32'hFFFF_FFFF);
    wr(OFS_MODULE_PARAMETERS, 32'h0000_0000);
    wr(12'h0F0, 32'hFFFF_FFFF);
    rc(OFS_MODULE_DESCRIPTION, MODULE_DESCRIPTION_ID);
    rc(OFS_MODULE_PARAMETERS, MODULE_PARAMETERS_RST);
    rc(12'h0F0, 32'h0000_0000);
    rc(12'h034, 32'h0000_0000);
    chk("ioN", 32'(ioOutN), 32'h0000_0007);
  endtask
  task automatic t_out();
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_0001);
    cyc(2);
    chk("ev", 32'(evOut), 32'h0000_0001);
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_003C);
    cyc(2);
    chk("ev", 32'(evOut), 32'h0000_0001);
    wr(OFS_IOOVR, 32'h0000_0404);
    cyc(2);
    chk("io", 32'(ioOut), 32'h0000_0005);
    chk("ioN", 32'(ioOutN), 32'h0000_0002);
    wr(OFS_IOOVR, 32'h0000_0000);
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_0002);
    cyc(2);
    chk("io", 32'(ioOut), 32'h0000_0000);
  endtask
  task automatic t_pre();
    wr(OFS_PRESCALER_CONFIG, 32'h0000_0103);
    wr(OFS_PREEVT, 32'h0000_0001);
    u_far.ticks(8);
    rc(OFS_COUNTER_VALUE, 32'h0000_0000);
    chk("pre", 32'(prescaler_event_config), 32'h0000_0000);
    wr(OFS_CTL, 32'h0000_0001);
    cyc(2);
    chk("pre", 32'(prescaler_event_config), 32'h0000_0000);
    u_far.ticks(2);
    chk("pre", 32'(prescaler_event_config), 32'h0000_0001);
    u_far.ticks(2);
    apb(1'b0, OFS_COUNTER_VALUE, 32'h0000_0000);
    v = q;
    u_far.ticks(8);
    apb(1'b0, OFS_COUNTER_VALUE, 32'h0000_0000);
    chk("step", q - v, 32'h0000_0002);
    wr(OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
    wr(OFS_COUNTER_VALUE, 32'h0000_FFFF);
    u_far.ticks(4);
    rc(OFS_RIS, 32'h0000_0001);
    wr(OFS_CTL, 32'h0000_0000);
    wr(OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
    rc(OFS_RIS, 32'h0000_0000);
  endtask
  task automatic t_irq();
    wr(OFS_DMA, 32'h0000_0002);
    wr(OFS_CONVERTER_TRIGGER_CONFIG, 32'h0000_0002);
    v = {dmaCnt, adcCnt};
    wr(OFS_IRQ_SET, 32'h0000_0002);
    cyc(2);
    chk("dma", 32'(dmaCnt - v[31:16]), 32'h0000_0001);
    chk("adc", 32'(adcCnt - v[15:0]), 32'h0000_0001);
    rc(OFS_RIS, 32'h0000_0002);
    rc(OFS_MIS, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    rc(OFS_MIS, 32'h0000_0002);
    wr(OFS_IRQ_CLEAR, 32'h0000_0002);
    rc(OFS_RIS, 32'h0000_0000);
    rc(OFS_MIS, 32'h0000_0000);
  endtask
  // Window of four words from index six; the fifth access must be dropped
  task automatic t_dma();
    logic [31:0] dv[5] = '{32'h3, 32'h11, 32'h5, 32'h0, 32'h7};
    wr(OFS_DMA, 32'h0004_0602);
    wr(OFS_IRQ_SET, 32'h0000_0002);
    wr(OFS_IRQ_CLEAR, 32'h0000_0002);
    foreach (dv[i]) wr(OFS_DMAWIN, dv[i]);
    rc(OFS_PRESCALER_CONFIG, 32'h0000_0003);
    rc(OFS_PREEVT, 32'h0000_0011);
    rc(OFS_FILT, 32'h0000_0005);
    rc(OFS_PARK, 32'h0000_0000);
    wr(OFS_IRQ_SET, 32'h0000_0002);
    wr(OFS_IRQ_CLEAR, 32'h0000_0002);
    rc(OFS_DMAWIN, 32'h0000_0003);
    rc(OFS_DMAWIN, 32'h0000_0011);
    wr(OFS_DMA, 32'h0000_0000);
  endtask
  // Channel 0 input pattern, first bit first
  task automatic seq(input logic [7:0] p);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      chIn <= {2'h0, p[i]};
    end
    @(posedge clk);
    chIn <= 3'h0;
    cyc(8);
  endtask
  task automatic t_filt();
    wr(OFS_FILT, 32'h0000_0002);
    wr(OFS_PRESCALER_CONFIG, 32'h0000_0000);
    wr(OFS_CHCFG0, 32'h0112_0000);
    wr(OFS_CTL, 32'h0000_0001);
    cyc(4);
    seq(8'h1B);
    chk("glitch", 32'(evOut), 32'h0000_0000);
    seq(8'h07);
    chk("capt", 32'(evOut), 32'h0000_0001);
    apb(1'b0, OFS_RIS, 32'h0000_0000);
    chk("capf", q & 32'h0000_0002, 32'h0000_0002);
    wr(OFS_CTL, 32'h0000_0000);
    wr(OFS_CHCFG0, 32'h0000_0000);
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_0002);
    wr(OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
  endtask
  task automatic t_park();
    wr(OFS_PARK, 32'h0000_0005);
    wr(OFS_DEADBAND_DELAY_VALUES, 32'h0000_0008);
    wr(OFS_DBEN, 32'h0000_0002);
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_0004);
    wr(OFS_CTL, 32'h0000_0001);
    debugHalt <= 1'b1;
    cyc(4);
    chk("db", 32'(ioOut), 32'h0000_0007);
    cyc(10);
    chk("park", 32'(ioOut), 32'h0000_0005);
    apb(1'b0, OFS_COUNTER_VALUE, 32'h0000_0000);
    v = q;
    rc(OFS_COUNTER_VALUE, v);
    debugHalt <= 1'b0;
    cyc(12);
    chk("run", 32'(ioOut), 32'h0000_0002);
    wr(OFS_CHCFG0, 32'h0000_0000);
    wr(OFS_FAULT, 32'h0000_0001);
    cyc(3);
    faultIn <= 1'b1;
    cyc(14);
    chk("fault", 32'(ioOut), 32'h0000_0005);
    faultIn <= 1'b0;
    wr(OFS_CTL, 32'h0000_0000);
  endtask
  // Toggle, clear and set hit output 2 on one compare: the clear must win
  task automatic t_cmp();
    wr(OFS_MANUAL_OUTPUT_CONTROL, 32'h0000_0010);
    wr(OFS_COUNTER_VALUE, 32'h0000_0000);
    wr(OFS_CHCFG0, 32'h0043_0020);
    wr(OFS_CHCFG0 + 12'h004, 32'h0041_0020);
    wr(OFS_CHCFG0 + 12'h008, 32'h0042_0020);
    chk("preset", 32'(evOut), 32'h0000_0006);
    wr(OFS_CTL, 32'h0000_0001);
    cyc(40);
    chk("prio", 32'(evOut), 32'h0000_0002);
    wr(OFS_CTL, 32'h0000_0000);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_out();
    t_pre();
    t_irq();
    t_dma();
    t_filt();
    t_park();
    t_cmp();
    chk("ioBad", 32'(ioBad), 32'h0000_0000);
    final_report();
  end
endmodule // general_timer_control_logic_bench
`default_nettype wire
